/* hw/usclk_pkg.sv */
// package: offsets, field layouts, reset values and modes of the clock generator
package usclk_pkg;
	// register byte offsets on the avalon slave
	localparam logic [3:0] USCLK_OFF_DIV_LOW  = 4'h0;
	localparam logic [3:0] USCLK_OFF_DIV_HIGH = 4'h4;
	localparam logic [3:0] USCLK_OFF_CTRL     = 4'h8;
	localparam logic [3:0] USCLK_OFF_STATUS   = 4'hc;
	// control register field positions
	localparam int USCLK_BIT_SYNC  = 0;
	localparam int USCLK_BIT_U2    = 1;
	localparam int USCLK_BIT_DIR   = 2;
	localparam int USCLK_BIT_POL   = 3;
	// reset values
	localparam logic [11:0] USCLK_DIV_RST  = 12'h000;
	localparam logic [3:0]  USCLK_CTRL_RST = 4'h0;
	localparam logic [31:0] USCLK_UNMAPPED = 32'h0000_0000;
	// last state index per bit (states per bit minus one) for each mode
	localparam logic [3:0] USCLK_DIV_NORMAL = 4'hf;
	localparam logic [3:0] USCLK_DIV_DOUBLE = 4'h7;
	localparam logic [3:0] USCLK_DIV_SYNC   = 4'h1;
	// clock modes
	typedef enum logic [1:0] {
		USCLK_ASYNC_NORMAL = 2'b00,
		USCLK_ASYNC_DOUBLE = 2'b01,
		USCLK_SYNC_MASTER  = 2'b10,
		USCLK_SYNC_SLAVE   = 2'b11
	} usclk_mode_t;
endpackage

/* hw/usclk_baud_gen.sv */
// programmable down-counter baud generator
module usclk_baud_gen
	import usclk_pkg::*;
#(
	parameter int DIV_W = 12
) (
	// clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             reset_i,
	input  wire logic             clk_en_i,
	// divisor and reload
	input  wire logic [DIV_W-1:0] divisor_i,
	input  wire logic             reload_i,
	// generator pulse
	output logic                  tick_o
);
	logic [DIV_W-1:0] count;
	logic [DIV_W-1:0] next_count;
	wire              at_zero = (count == '0);

	initial begin
		if (DIV_W < 1 || DIV_W > 16) begin
			$error("usclk_baud_gen: DIV_W out of range");
		end
	end

	// reload on zero or on a low-byte write, else count down
	assign next_count = (at_zero || reload_i) ? divisor_i
		: count - {{(DIV_W-1){1'b0}}, 1'b1};

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			count  <= '0;
			tick_o <= 1'b0;
		end else if (clk_en_i) begin
			count  <= next_count;
			tick_o <= at_zero && !reload_i;
		end
	end
endmodule

/* hw/usclk_clock_gen.sv */
// serial transceiver clock generation with avalon register slave
module usclk_clock_gen
	import usclk_pkg::*;
#(
	parameter int DIV_W = 12
) (
	// clock, reset, enable
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic        clk_en_i,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	// transfer clock pin
	input  wire logic        xfer_clk_in_i,
	output logic             xfer_clk_out_o,
	output logic             xfer_clk_oe_n_o,
	// enables to transmitter and receiver
	output logic             tx_bit_en_o,
	output logic             rx_sample_en_o,
	output logic             tx_change_en_o,
	output logic             rx_base_en_o,
	output logic [1:0]       mode_o
);
	initial begin
		if (DIV_W != 12) begin
			$error("usclk_clock_gen: divisor must be twelve bits");
		end
	end

	////////////////////////////////////////////////////////////////////
	// registers
	logic [DIV_W-1:0] baud_divisor;
	logic [3:0]       ctrl;
	logic             ack;
	logic [31:0]      next_readdata;

	wire sync_mode_select         = ctrl[USCLK_BIT_SYNC];
	wire double_speed             = ctrl[USCLK_BIT_U2];
	wire xfer_clock_pin_direction = ctrl[USCLK_BIT_DIR];
	wire edge_polarity_select     = ctrl[USCLK_BIT_POL];

	// one wait state: request is taken on the edge where ack is high
	wire req       = (avs_read_i || avs_write_i) && !ack;
	wire wr_take   = avs_write_i && ack;
	wire wr_low    = wr_take && avs_address_i == USCLK_OFF_DIV_LOW
		&& avs_byteenable_i[0];
	wire wr_high   = wr_take && avs_address_i == USCLK_OFF_DIV_HIGH
		&& avs_byteenable_i[0];
	wire wr_ctrl   = wr_take && avs_address_i == USCLK_OFF_CTRL
		&& avs_byteenable_i[0];

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			ack <= 1'b0;
		end else if (clk_en_i) begin
			ack <= req;
		end
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			baud_divisor <= USCLK_DIV_RST;
			ctrl         <= USCLK_CTRL_RST;
		end else if (clk_en_i) begin
			if (wr_low) begin
				baud_divisor[7:0] <= avs_writedata_i[7:0];
			end
			if (wr_high) begin
				baud_divisor[11:8] <= avs_writedata_i[3:0];
			end
			if (wr_ctrl) begin
				ctrl <= avs_writedata_i[3:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// mode selection
	usclk_mode_t mode;
	assign mode = !sync_mode_select
		? (double_speed ? USCLK_ASYNC_DOUBLE : USCLK_ASYNC_NORMAL)
		: (xfer_clock_pin_direction ? USCLK_SYNC_MASTER : USCLK_SYNC_SLAVE);

	wire is_sync  = (mode == USCLK_SYNC_MASTER) || (mode == USCLK_SYNC_SLAVE);
	wire is_slave = (mode == USCLK_SYNC_SLAVE);

	function automatic logic [3:0] states_per_bit(input usclk_mode_t m);
		unique case (m)
			USCLK_ASYNC_NORMAL: states_per_bit = USCLK_DIV_NORMAL;
			USCLK_ASYNC_DOUBLE: states_per_bit = USCLK_DIV_DOUBLE;
			USCLK_SYNC_MASTER:  states_per_bit = USCLK_DIV_SYNC;
			USCLK_SYNC_SLAVE:   states_per_bit = USCLK_DIV_SYNC;
		endcase
	endfunction

	wire [3:0] last_state = states_per_bit(mode);

	////////////////////////////////////////////////////////////////////
	// baud generator
	logic baud_tick;
	// low-byte write reloads with the byte being written, not the old one
	wire [DIV_W-1:0] div_load = wr_low
		? {baud_divisor[11:8], avs_writedata_i[7:0]} : baud_divisor;

	usclk_baud_gen #(
		.DIV_W (DIV_W)
	) u_baud (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.clk_en_i  (clk_en_i),
		.divisor_i (div_load),
		.reload_i  (wr_low),
		.tick_o    (baud_tick)
	);

	////////////////////////////////////////////////////////////////////
	// transmit prescaler and receive phase counter
	logic [3:0] tx_div;
	logic [3:0] rx_phase;
	logic       xck_int;

	wire tx_wrap   = baud_tick && (tx_div >= last_state);
	wire [3:0] next_tx_div = !baud_tick ? tx_div
		: (tx_wrap ? 4'h0 : tx_div + 4'h1);
	wire [3:0] next_rx_phase = !baud_tick ? rx_phase
		: ((rx_phase >= last_state) ? 4'h0 : rx_phase + 4'h1);

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			tx_div   <= 4'h0;
			rx_phase <= 4'h0;
			xck_int  <= 1'b0;
		end else if (clk_en_i) begin
			tx_div   <= next_tx_div;
			rx_phase <= next_rx_phase;
			if (mode == USCLK_SYNC_MASTER && baud_tick) begin
				xck_int <= !xck_int;
			end else if (!is_sync) begin
				xck_int <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// external clock synchroniser and edge detector
	logic xck_meta;
	logic xck_sync;
	logic xck_prev;

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			xck_meta <= 1'b0;
			xck_sync <= 1'b0;
			xck_prev <= 1'b0;
		end else if (clk_en_i) begin
			xck_meta <= xfer_clk_in_i;
			xck_sync <= xck_meta;
			xck_prev <= xck_sync;
		end
	end

	// pulses last one cycle so serial logic stays on sys_clk
	wire ext_rise = is_slave && xck_sync && !xck_prev;
	wire ext_fall = is_slave && !xck_sync && xck_prev;
	// master edges follow the internal toggle
	wire int_rise = mode == USCLK_SYNC_MASTER && baud_tick && !xck_int;
	wire int_fall = mode == USCLK_SYNC_MASTER && baud_tick && xck_int;
	wire rise     = ext_rise || int_rise;
	wire fall     = ext_fall || int_fall;

	wire sync_change = edge_polarity_select ? fall : rise;
	wire sync_sample = edge_polarity_select ? rise : fall;

	////////////////////////////////////////////////////////////////////
	// outputs
	always_comb begin
		next_readdata = USCLK_UNMAPPED;
		unique case (avs_address_i)
			USCLK_OFF_DIV_LOW:  next_readdata[7:0] = baud_divisor[7:0];
			USCLK_OFF_DIV_HIGH: next_readdata[3:0] = baud_divisor[11:8];
			USCLK_OFF_CTRL:     next_readdata[3:0] = ctrl;
			USCLK_OFF_STATUS:   next_readdata[5:0] = {xck_sync, xck_int,
				2'b00, mode};
			default:            next_readdata = USCLK_UNMAPPED;
		endcase
	end

	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			avs_readdata_o    <= 32'h0000_0000;
			avs_waitrequest_o <= 1'b1;
			xfer_clk_out_o    <= 1'b0;
			xfer_clk_oe_n_o   <= 1'b1;
			tx_bit_en_o       <= 1'b0;
			rx_sample_en_o    <= 1'b0;
			tx_change_en_o    <= 1'b0;
			rx_base_en_o      <= 1'b0;
			mode_o            <= USCLK_ASYNC_NORMAL;
		end else if (clk_en_i) begin
			avs_waitrequest_o <= !req;
			if (req && avs_read_i) begin
				avs_readdata_o <= next_readdata;
			end
			// pin driven only in sync master
			xfer_clk_oe_n_o <= !(mode == USCLK_SYNC_MASTER);
			xfer_clk_out_o  <= (mode == USCLK_SYNC_MASTER) && next_xck();
			tx_bit_en_o     <= is_sync ? sync_change : tx_wrap;
			tx_change_en_o  <= is_sync && sync_change;
			rx_sample_en_o  <= is_sync ? sync_sample : baud_tick;
			rx_base_en_o    <= is_slave ? sync_sample : baud_tick;
			mode_o          <= mode;
		end
	end

	function automatic logic next_xck();
		next_xck = (mode == USCLK_SYNC_MASTER && baud_tick) ? !xck_int
			: xck_int;
	endfunction
endmodule

/* tb/usclk_clock_gen_properties.sv */
// checker: port-level properties of the clock generator
module usclk_clock_gen_properties
	import usclk_pkg::*;
(
	// watched ports
	input wire logic       sys_clk_i,
	input wire logic       reset_i,
	input wire logic       avs_read_i,
	input wire logic       avs_write_i,
	input wire logic       avs_waitrequest_o,
	input wire logic       xfer_clk_in_i,
	input wire logic       xfer_clk_out_o,
	input wire logic       xfer_clk_oe_n_o,
	input wire logic       tx_bit_en_o,
	input wire logic       rx_sample_en_o,
	input wire logic       tx_change_en_o,
	input wire logic       rx_base_en_o,
	input wire logic [1:0] mode_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);
	////////////////////////////////////////////////////////////////////////
	req_answer_a: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("request not answered");
	wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	pin_dir_a: assert property (
		xfer_clk_oe_n_o == (mode_o != USCLK_SYNC_MASTER))
		else $error("pin direction wrong for mode");
	out_idle_a: assert property (xfer_clk_oe_n_o |-> !xfer_clk_out_o)
		else $error("pin output active while released");
	slave_delay_a: assert property (
		mode_o == USCLK_SYNC_SLAVE && $changed(xfer_clk_in_i)
		|-> ##[2:3] (tx_change_en_o || rx_sample_en_o))
		else $error("slave edge not seen");
	pulse_single_a: assert property (tx_bit_en_o |=> !tx_bit_en_o)
		else $error("bit enable longer than one cycle");
	rx_direct_a: assert property (
		!mode_o[1] |-> rx_sample_en_o == rx_base_en_o)
		else $error("receiver not on generator tick");
	change_sync_a: assert property (!mode_o[1] |-> !tx_change_en_o)
		else $error("change enable in async mode");
endmodule

/* tb/usclk_peer.sv */
// remote peer: drives the transfer clock pin in slave tests
module usclk_peer #(
	parameter int HALF = 5
) (
	// clock and control
	input  wire logic sys_clk_i,
	input  wire logic reset_i,
	input  wire logic run_i,
	// pin
	output logic      xck_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// half period of 5 keeps the pin below a quarter of the clock
	always_ff @(posedge sys_clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt   <= 0;
			xck_o <= 1'b0;
		end else if (run_i) begin
			cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
			if (cnt == HALF - 1)
				xck_o <= !xck_o;
		end
	end
endmodule

/* tb/usclk_clock_gen_bench.sv */
// self-checking bench for the clock generator
module usclk_clock_gen_bench import usclk_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic        sys_clk_i = 1'b0;
	logic        reset_i = 1'b1;
	logic        clk_en_i = 1'b1;
	logic [3:0]  avs_address_i = 4'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [3:0]  avs_byteenable_i = 4'hf;
	logic [31:0] avs_readdata_o, q;
	logic        avs_waitrequest_o, xfer_clk_in_i, xfer_clk_out_o;
	logic        xfer_clk_oe_n_o, tx_bit_en_o, rx_sample_en_o;
	logic        tx_change_en_o, rx_base_en_o;
	logic        run = 1'b0;
	logic [1:0]  mode_o;
	logic [11:0] d;
	int          n_mismatch = 0, total_checks = 0, cycles = 0, seed = 77, n;
	int          fac[4] = '{16, 8, 2, 0};
	always #25 sys_clk_i = !sys_clk_i;
	usclk_clock_gen u_usclk_clock_gen (.*);
	usclk_peer u_usclk_peer (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
		.run_i(run), .xck_o(xfer_clk_in_i));
	////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (n_mismatch == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] wd);
		@(posedge sys_clk_i);
		avs_write_i     <= w;
		avs_read_i      <= !w;
		avs_address_i   <= a;
		avs_writedata_i <= wd;
		do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i  <= 1'b0;
	endtask
	// cycles between two bit enables (s=1) or receive base enables (s=0)
	task automatic gap(input logic s);
		do @(posedge sys_clk_i); while (!(s ? tx_bit_en_o : rx_base_en_o));
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (!(s ? tx_bit_en_o : rx_base_en_o));
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [3:0] ctl[5] = '{4'h0, 4'h2, 4'h7, 4'h1, 4'h9};
		repeat (2) @(posedge sys_clk_i);
		reset_i <= 1'b0;
		bus(1'b0, USCLK_OFF_CTRL, 32'h0);
		chk(q, {28'h0, USCLK_CTRL_RST});
		bus(1'b0, 4'h2, 32'h0);
		chk(q, USCLK_UNMAPPED);
		d = 12'($random(seed));
		bus(1'b1, USCLK_OFF_DIV_HIGH, {28'h0, d[11:8]});
		bus(1'b1, USCLK_OFF_DIV_LOW, {24'h0, d[7:0]});
		avs_byteenable_i <= 4'he;
		bus(1'b1, USCLK_OFF_DIV_LOW, 32'h0);
		avs_byteenable_i <= 4'hf;
		bus(1'b0, USCLK_OFF_DIV_HIGH, 32'h0);
		chk(q, {28'h0, d[11:8]});
		gap(1'b0);
		chk(32'(n), 32'(d) + 32'h1);
		// double speed set in master mode (index 2) must be ignored
		for (int m = 0; m < 5; m++) begin
			d = (m == 0) ? 12'h000 : 12'($random(seed)) & 12'h007;
			bus(1'b1, USCLK_OFF_CTRL, {28'h0, ctl[m]});
			bus(1'b1, USCLK_OFF_DIV_HIGH, 32'h0);
			bus(1'b1, USCLK_OFF_DIV_LOW, {24'h0, d[7:0]});
			run <= (m > 2);
			bus(1'b0, USCLK_OFF_STATUS, 32'h0);
			chk({30'h0, q[1:0]}, (m > 2) ? 32'h3 : 32'(m));
			chk({30'h0, mode_o}, (m > 2) ? 32'h3 : 32'(m));
			gap(1'b1);
			chk(32'(n), (m > 2) ? 32'h0a : 32'(fac[m] * (d + 1)));
			gap(1'b0);
			chk(32'(n), (m > 2) ? 32'h0a : 32'(d) + 32'h1);
			if (m > 2) begin
				do @(posedge sys_clk_i); while (!tx_change_en_o);
				chk({31'h0, xfer_clk_in_i}, {31'h0, m == 3});
			end
		end
		results();
	end
endmodule
bind usclk_clock_gen usclk_clock_gen_properties u_props (.*);
